// [rtl/pdn_pkg.sv]
/*
  Package of the programmable divide-by-N counter: register map, field
  positions, reset values, first-section moduli and the counter state carrier.
  Assumes it is compiled before every other design file.
*/
package pdn_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_PRESET = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  localparam int CTRL_A_BIT     = 0;
  localparam int CTRL_B_BIT     = 1;
  localparam int CTRL_C_BIT     = 2;
  localparam int CTRL_LATCH_BIT = 3;
  localparam logic [3:0] CTRL_RESET   = 4'h0;
  localparam logic [15:0] PRESET_RESET = 16'h0000;

  localparam int STAT_FIRST_LSB = 0;
  localparam int STAT_DEC1_LSB  = 4;
  localparam int STAT_DEC2_LSB  = 8;
  localparam int STAT_DEC3_LSB  = 12;
  localparam int STAT_LAST_LSB  = 16;
  localparam int STAT_OUT_BIT   = 19;
  localparam int STAT_HOLD_BIT  = 20;
  localparam int STAT_ARM_BIT   = 21;

  // ---------------------------------------------------------------------------
  // Counter constants
  // ---------------------------------------------------------------------------
  localparam int PRESET_W = 16;
  localparam logic [3:0] DEC_TOP   = 4'h9;
  localparam logic [3:0] MOD2_TOP  = 4'h1;
  localparam logic [3:0] MOD4_TOP  = 4'h3;
  localparam logic [3:0] MOD5_TOP  = 4'h4;
  localparam logic [3:0] MOD8_TOP  = 4'h7;
  localparam logic [3:0] MOD10_TOP = 4'h9;
  localparam logic [3:0] EARLY_MAX = 4'h2;

  typedef enum logic [2:0] {
    PDN_DIV2,
    PDN_DIV4,
    PDN_DIV5,
    PDN_DIV8,
    PDN_DIV10,
    PDN_HOLD
  } pdn_mode_t;

  typedef struct packed {
    logic [2:0] last;
    logic [3:0] dec3;
    logic [3:0] dec2;
    logic [3:0] dec1;
    logic [3:0] first;
  } pdn_cnt_t;

endpackage : pdn_pkg

// [rtl/pdn_counter.sv]
/*
  Programmable divide-by-N down-counter with an APB register port.
  The counted clock arrives on a pin and is synchronised into pclk; all counter state
  advances on its synchronised rising edge, the APB registers and the output clear on latch release on pclk. Assumes pdn_pkg is compiled first.
*/
// The APB register port and the register addresses were decided locally.
// Behaviour
// - Divide incoming clock by N, 3 to 15999.
// - Load start value from sixteen preset lines.
// - Output event one input period, every N.
// - Mode inputs pick first and last moduli.
// - Low preset lines split first/last section.
// - Three decades preset from lines five-sixteen.
// - Each first-section cycle decrements upper count.
// - Decades accept presets up to fifteen.
// - Ratio is modulus times upper plus first.
// - Mode b,c low loads and holds.
// - Leaving hold starts countdown from preset.
// - First edge after hold only arms.
// - Hold within two clocks keeps due pulse.
// - Reload preset at every output pulse.
// - Latch high keeps output high after pulse.
// - Latch low gives one-period output pulse.
// - Standard maximum 9999 or 15999.
// - Out-of-range decades extend the maximum.
`timescale 1ns/1ps
module pdn_counter (
  input  wire logic        pclk,      // Bus and logic clock, 100 MHz.
  input  wire logic        presetn,   // Asynchronous reset, active low.
  input  wire logic        psel,      // APB select.
  input  wire logic        penable,   // APB access phase.
  input  wire logic        pwrite,    // APB direction, high for write.
  input  wire logic [11:0] paddr,     // APB byte address.
  input  wire logic [31:0] pwdata,    // APB write data.
  output logic             pready,    // APB ready.
  output logic      [31:0] prdata,    // APB read data.
  output logic             pslverr,   // APB error on unmapped address.
  input  wire logic        count_clk, // Clock to be divided, from a pin.
  output logic             div_out    // Divided output.
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  function automatic pdn_pkg::pdn_mode_t mode_of(input logic [3:0] ctrl);
    logic a;
    logic b;
    logic c;
    a = ctrl[pdn_pkg::CTRL_A_BIT];
    b = ctrl[pdn_pkg::CTRL_B_BIT];
    c = ctrl[pdn_pkg::CTRL_C_BIT];
    if (!b && !c) begin
      mode_of = pdn_pkg::PDN_HOLD;
    end else if (b && c) begin
      mode_of = a ? pdn_pkg::PDN_DIV2 : pdn_pkg::PDN_DIV4;
    end else if (c) begin
      mode_of = a ? pdn_pkg::PDN_DIV5 : pdn_pkg::PDN_DIV8;
    end else begin
      mode_of = pdn_pkg::PDN_DIV10;
    end
  endfunction : mode_of

  function automatic logic [3:0] top_of(input pdn_pkg::pdn_mode_t m);
    unique case (m)
      pdn_pkg::PDN_DIV2:  top_of = pdn_pkg::MOD2_TOP;
      pdn_pkg::PDN_DIV4:  top_of = pdn_pkg::MOD4_TOP;
      pdn_pkg::PDN_DIV5:  top_of = pdn_pkg::MOD5_TOP;
      pdn_pkg::PDN_DIV8:  top_of = pdn_pkg::MOD8_TOP;
      default:            top_of = pdn_pkg::MOD10_TOP;
    endcase
  endfunction : top_of

  // Splits the preset lines into sections for a mode.
  function automatic pdn_pkg::pdn_cnt_t split_of(input logic [15:0] jam,
                                                 input pdn_pkg::pdn_mode_t m);
    pdn_pkg::pdn_cnt_t s;
    s      = '0;
    s.dec1 = jam[7:4];
    s.dec2 = jam[11:8];
    s.dec3 = jam[15:12];
    unique case (m)
      pdn_pkg::PDN_DIV2: begin
        s.first = {3'h0, jam[0]};
        s.last  = jam[3:1];
      end
      pdn_pkg::PDN_DIV4: begin
        s.first = {2'h0, jam[1:0]};
        s.last  = {1'h0, jam[3:2]};
      end
      pdn_pkg::PDN_DIV5, pdn_pkg::PDN_DIV8: begin
        s.first = {1'h0, jam[2:0]};
        s.last  = {2'h0, jam[3]};
      end
      default: begin
        s.first = jam[3:0];
        s.last  = 3'h0;
      end
    endcase
    split_of = s;
  endfunction : split_of

  // ---------------------------------------------------------------------------
  // Input synchroniser for the counted clock
  // ---------------------------------------------------------------------------
  logic [2:0] sync_q;
  logic       lvl_q;
  logic       lvl_d;
  logic       tick;

  always_comb begin
    lvl_d = lvl_q;
    if (sync_q[1] == sync_q[2]) begin
      lvl_d = sync_q[2];
    end
  end

  assign tick = lvl_d && !lvl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h0;
      lvl_q  <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], count_clk};
      lvl_q  <= lvl_d;
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  logic [3:0]  ctrl_q;
  logic [3:0]  ctrl_d;
  logic [15:0] jam_q;
  logic [15:0] jam_d;
  logic        pready_q;
  logic        pready_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] status;
  logic        acc;
  logic        mapped;

  pdn_pkg::pdn_cnt_t cnt_q;
  pdn_pkg::pdn_cnt_t cnt_d;
  logic              arm_q;
  logic              arm_d;
  logic              out_q;
  logic              out_d;

  always_comb begin
    status = '0;
    status[pdn_pkg::STAT_FIRST_LSB +: 4] = cnt_q.first;
    status[pdn_pkg::STAT_DEC1_LSB +: 4]  = cnt_q.dec1;
    status[pdn_pkg::STAT_DEC2_LSB +: 4]  = cnt_q.dec2;
    status[pdn_pkg::STAT_DEC3_LSB +: 4]  = cnt_q.dec3;
    status[pdn_pkg::STAT_LAST_LSB +: 3]  = cnt_q.last;
    status[pdn_pkg::STAT_OUT_BIT]        = out_q;
    status[pdn_pkg::STAT_HOLD_BIT]       = (mode_of(ctrl_q) == pdn_pkg::PDN_HOLD);
    status[pdn_pkg::STAT_ARM_BIT]        = arm_q;
  end

  assign acc    = psel && penable && !pready_q;
  assign mapped = (paddr == pdn_pkg::ADDR_CTRL) || (paddr == pdn_pkg::ADDR_PRESET) ||
                  (paddr == pdn_pkg::ADDR_STATUS);

  always_comb begin
    ctrl_d    = ctrl_q;
    jam_d     = jam_q;
    pready_d  = acc;
    prdata_d  = '0;
    pslverr_d = 1'b0;
    if (acc) begin
      pslverr_d = !mapped;
      if (!pwrite) begin
        unique case (paddr)
          pdn_pkg::ADDR_CTRL:   prdata_d = {28'h0, ctrl_q};
          pdn_pkg::ADDR_PRESET: prdata_d = {16'h0, jam_q};
          pdn_pkg::ADDR_STATUS: prdata_d = status;
          default:              prdata_d = '0;
        endcase
      end
    end
    if (psel && penable && pready_q && pwrite && !pslverr_q) begin
      if (paddr == pdn_pkg::ADDR_CTRL) begin
        ctrl_d = pwdata[3:0];
      end
      if (paddr == pdn_pkg::ADDR_PRESET) begin
        jam_d = pwdata[pdn_pkg::PRESET_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= pdn_pkg::CTRL_RESET;
      jam_q     <= pdn_pkg::PRESET_RESET;
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      jam_q     <= jam_d;
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------------------
  // Counting sections
  // ---------------------------------------------------------------------------
  pdn_pkg::pdn_mode_t mode;
  pdn_pkg::pdn_cnt_t  load_val;
  logic               latch;
  logic               latch_q;
  logic               hold;
  logic               upper_zero;
  logic               term;
  logic               pulse;
  logic [3:0]         pend_q;
  logic [3:0]         pend_d;
  logic [3:0]         early;

  assign mode       = mode_of(ctrl_q);
  assign hold       = (mode == pdn_pkg::PDN_HOLD);
  assign latch      = ctrl_q[pdn_pkg::CTRL_LATCH_BIT];
  assign load_val   = split_of(jam_q, mode);
  assign upper_zero = (cnt_q.last == 3'h0) && (cnt_q.dec3 == 4'h0) &&
                      (cnt_q.dec2 == 4'h0) && (cnt_q.dec1 == 4'h0);
  assign term       = upper_zero && (cnt_q.first <= 4'h1);

  always_comb begin
    cnt_d  = cnt_q;
    arm_d  = arm_q;
    pend_d = pend_q;
    pulse  = 1'b0;
    early  = '0;
    if (tick) begin
      if (hold) begin
        // A pulse due within two counts still comes out on time.
        early = arm_q ? pend_q : ((upper_zero && cnt_q.first <= pdn_pkg::EARLY_MAX) ?
                                  cnt_q.first : 4'h0);
        pulse  = (early == 4'h1);
        pend_d = (early != 4'h0) ? early - 4'h1 : 4'h0;
        cnt_d  = load_val;
        arm_d  = 1'b1;
      end else if (arm_q) begin
        cnt_d  = load_val;
        arm_d  = 1'b0;
        pend_d = 4'h0;
      end else if (term) begin
        pulse = 1'b1;
        cnt_d = load_val;
      end else if (cnt_q.first == 4'h0) begin
        cnt_d.first = top_of(mode);
        if (cnt_q.dec1 != 4'h0) begin
          cnt_d.dec1 = cnt_q.dec1 - 4'h1;
        end else begin
          cnt_d.dec1 = pdn_pkg::DEC_TOP;
          if (cnt_q.dec2 != 4'h0) begin
            cnt_d.dec2 = cnt_q.dec2 - 4'h1;
          end else begin
            cnt_d.dec2 = pdn_pkg::DEC_TOP;
            if (cnt_q.dec3 != 4'h0) begin
              cnt_d.dec3 = cnt_q.dec3 - 4'h1;
            end else begin
              cnt_d.dec3 = pdn_pkg::DEC_TOP;
              cnt_d.last = cnt_q.last - 3'h1;
            end
          end
        end
      end else begin
        cnt_d.first = cnt_q.first - 4'h1;
      end
    end
  end

  always_comb begin
    if (latch) begin
      out_d = out_q || pulse;
    end else if (tick) begin
      out_d = pulse;
    end else begin
      out_d = out_q && !latch_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= '0;
      arm_q   <= 1'b1;
      pend_q  <= 4'h0;
      out_q   <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      arm_q   <= arm_d;
      pend_q  <= pend_d;
      out_q   <= out_d;
      latch_q <= latch;
    end
  end

  assign div_out = out_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_bus_access;
    psel && penable && !pready_q;
  endsequence

  sequence s_leave_hold;
    tick && !hold && arm_q;
  endsequence

  sequence s_borrow;
    tick && !hold && !arm_q && !term && cnt_q.first == 4'h0;
  endsequence

  bus_answer_a: assert property (s_bus_access |=> pready_q && pslverr_q == !$past(mapped))
    else $error("bus access not answered one cycle later");
  preset_write_a: assert property (psel && penable && pready_q && pwrite && !pslverr_q &&
                                   paddr == pdn_pkg::ADDR_PRESET
                                   |=> jam_q == $past(pwdata[15:0]))
    else $error("preset write did not land");
  hold_load_a: assert property (tick && hold |=> arm_q && cnt_q == $past(load_val))
    else $error("hold did not load the preset");
  hold_quiet_a: assert property (tick && hold && arm_q && pend_q == 4'h0 && !latch
                                 |=> !div_out)
    else $error("output pulsed while held in preset");
  // A latched output may carry over into the arming edge, but nothing new may pulse there.
  arm_edge_a: assert property (s_leave_hold
                               |=> !arm_q && cnt_q == $past(load_val) &&
                                   div_out == ($past(latch) && $past(div_out)))
    else $error("first edge after hold did not only arm");
  reload_a: assert property (tick && !hold && !arm_q && term
                             |=> div_out && cnt_q == $past(load_val))
    else $error("terminal count did not pulse and reload");
  first_dec_a: assert property (tick && !hold && !arm_q && !term && cnt_q.first != 4'h0
                                |=> cnt_q.first == $past(cnt_q.first) - 4'h1)
    else $error("first section did not count down");
  borrow_a: assert property (s_borrow
                             |=> cnt_q.first == $past(top_of(mode)))
    else $error("first section did not wrap to modulus minus one");
  dec_step_a: assert property (s_borrow ##0 (cnt_q.dec1 != 4'h0)
                               |=> cnt_q.dec1 == $past(cnt_q.dec1) - 4'h1)
    else $error("first decade did not step down by one");
  dec_wrap_a: assert property (s_borrow ##0 (cnt_q.dec1 == 4'h0)
                               |=> cnt_q.dec1 == pdn_pkg::DEC_TOP)
    else $error("first decade did not wrap to nine");
  latch_keep_a: assert property (latch && div_out ##1 latch |-> div_out)
    else $error("latched output dropped while latch enable high");
  latch_drop_a: assert property (!latch && latch_q && !tick |=> !div_out)
    else $error("latched output kept after latch enable fell");
  pulse_width_a: assert property (!latch && tick && !pulse ##1 !latch |-> !div_out)
    else $error("output longer than one input period");
  early_pulse_a: assert property (tick && hold && !arm_q && upper_zero
                                  && cnt_q.first == 4'h1 |=> div_out)
    else $error("due pulse lost on entering hold");
  early_pend_a: assert property (tick && hold && !arm_q && upper_zero
                                 && cnt_q.first == 4'h2 |=> pend_q == 4'h1)
    else $error("pulse due in two counts not kept pending");
  pend_fire_a: assert property (tick && hold && arm_q && pend_q == 4'h1 |=> div_out)
    else $error("pending pulse not emitted at its due count");

endmodule : pdn_counter

// [bench/pdn_count_src.sv]
/*
  Partner model: source of the clock to be divided, made in the pclk domain.
  Assumes pclk and presetn of the bench; the clock stands low while en is low.
*/
`timescale 1ns/1ps
module pdn_count_src #(
  parameter int HALF = 3
) (
  input  wire logic pclk,      // Bench clock.
  input  wire logic presetn,   // Reset, active low.
  input  wire logic en,        // Run the clock to be divided.
  output logic      count_clk  // Clock towards the counter.
);
  int cnt;

  // ---------------------------------------------------------------------------
  // Clock generation
  // ---------------------------------------------------------------------------
  // Each phase lasts HALF pclk cycles so the synchroniser always sees it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || !en) begin
      cnt       <= 0;
      count_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt       <= 0;
      count_clk <= ~count_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : pdn_count_src

// [bench/programmable_divide_by_n_counter_test.sv]
/*
  Self-checking bench of the divide-by-N counter: APB access, all modes,
  hold, latch. Assumes pdn_pkg, pdn_counter and pdn_count_src compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
module programmable_divide_by_n_counter_test;
  localparam int         MODS[5]  = '{2, 4, 5, 8, 10};
  localparam logic [3:0] CODES[5] = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h3};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        count_clk, div_out, src_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] p;
  int          n_mismatch, checks, cycles, n, c, w;

  pdn_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .count_clk(count_clk), .div_out(div_out));
  pdn_count_src #(.HALF(3)) src (.pclk(pclk), .presetn(presetn), .en(src_en),
    .count_clk(count_clk));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // Entered and left just after a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_rise(input int lim);
    logic last, hit;
    last = div_out;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
      hit = div_out === 1'b1 && last === 1'b0;
      last = div_out;
    end while (!hit && c < lim);
  endtask : wait_rise

  task automatic width();
    w = 1;
    while (w < 100) begin
      @(posedge pclk);
      if (div_out !== 1'b1) break;
      w++;
    end
  endtask : width

  function automatic int exp_n(input int m, input logic [15:0] q);
    int last, first;
    case (m)
      0: begin first = q[0]; last = q[3:1]; end
      1: begin first = q[1:0]; last = q[3:2]; end
      2, 3: begin first = q[2:0]; last = q[3]; end
      default: begin first = q[3:0]; last = 0; end
    endcase
    return MODS[m] * (1000 * last + 100 * q[15:12] + 10 * q[11:8] + q[7:4]) + first;
  endfunction : exp_n

  // Holds five ticks with preset p, then leaves hold with the clock restarted.
  task automatic start(input int m, input logic [3:0] ctl);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, {16'h0, p});
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rd, {16'h0, p})
    src_en <= 1'b1;
    repeat (30) @(posedge pclk);
    `CHK(div_out, 1'b0)
    src_en <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, {16'h0030, p})
    apb(1'b1, 12'h000, {28'h0, ctl});
    src_en <= 1'b1;
    n = exp_n(m, p);
    wait_rise(6 * n + 40);
    `CHK(c >= 6 * n + 6 && c <= 6 * n + 12, 1'b1)
  endtask : start

  task automatic tally_and_finish();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, src_en, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    void'($urandom(32'h372a0075));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    for (int m = 0; m < 5; m++) begin
      p = {4'h0, 4'($urandom % 2), 4'(1 + $urandom % 15), 4'($urandom % MODS[m])};
      if (m == 0) p[1] = 1'b1;
      start(m, CODES[m]);
      width();
      `CHK(w, 6)
      wait_rise(6 * n + 20);
      `CHK(w + c, 6 * n)
    end
    start(4, 4'hb);
    repeat (18) @(posedge pclk);
    `CHK(div_out, 1'b1)
    apb(1'b1, 12'h000, 32'h3);
    @(posedge pclk);
    `CHK(div_out, 1'b0)
    tally_and_finish();
  end
endmodule : programmable_divide_by_n_counter_test
